// ===== dirc_ctrl.v
/*
 * control-pin logic: branch condition, external flag, interrupt flags, priority,
 * acknowledge, reset handling, map select sampling and machine clock output.
 * assumes inputs synchronous to aclk; registers reached over AXI4-Lite.
 */
// How it works
// - conditional instruction taken only when branch condition input is low.
// - external flag set by flag instruction or by loading status word one.
// - reset forces external flag high.
// - output-float low tristates flag, acknowledge and machine clock outputs.
// - acknowledge asserted while vector address of accepted interrupt is fetched.
// - four lines prioritized, masked by mask register and global disable bit 9.
// - pending interrupts latched in flag register; readable, write-one clears.
// - nonmaskable interrupt is never blocked by disable bit or mask.
// - nonmaskable interrupt diverts flow to its own vector.
// - reset low stops execution and holds program counter at zero.
// - after reset release fetching starts at program address zero.
// - map select low at reset maps internal program ROM.
// - map select high at reset sends all program accesses external.
// - map select sampled only during reset; later changes ignored.
// - software may override the sampled map choice through the mode bit.
// - machine clock toggles each cycle; machine cycle bounded by its rising edges.
`include "dirc_regs.vh"
`timescale 1ns/10ps
module dirc_ctrl (
    aclk,
    aresetn,
    system_reset_in_n,
    memory_map_select,
    output_float_n,
    branch_condition_in,
    branch_test,
    branch_taken,
    flag_instr,
    flag_instr_value,
    ext_irq_line_1,
    ext_irq_line_2,
    ext_irq_line_3,
    ext_irq_line_4,
    nmi_in_n,
    fetch_enable,
    irq_vector_valid,
    address_lines,
    internal_rom_mapped,
    external_flag_out,
    external_flag_out_en_n,
    irq_ack_out,
    irq_ack_out_en_n,
    machine_clock_out,
    machine_clock_out_en_n,
    awaddr,
    awvalid,
    awready,
    wdata,
    wstrb,
    wvalid,
    wready,
    bresp,
    bvalid,
    bready,
    araddr,
    arvalid,
    arready,
    rdata,
    rresp,
    rvalid,
    rready
);
    input wire aclk;
    input wire aresetn;
    input wire system_reset_in_n;
    input wire memory_map_select;
    input wire output_float_n;
    input wire branch_condition_in;
    input wire branch_test;
    output wire branch_taken;
    input wire flag_instr;
    input wire flag_instr_value;
    input wire ext_irq_line_1;
    input wire ext_irq_line_2;
    input wire ext_irq_line_3;
    input wire ext_irq_line_4;
    input wire nmi_in_n;
    output wire fetch_enable;
    output wire irq_vector_valid;
    output wire [15:0] address_lines;
    output wire internal_rom_mapped;
    output wire external_flag_out;
    output wire external_flag_out_en_n;
    output wire irq_ack_out;
    output wire irq_ack_out_en_n;
    output wire machine_clock_out;
    output wire machine_clock_out_en_n;
    input wire [3:0] awaddr;
    input wire awvalid;
    output wire awready;
    input wire [31:0] wdata;
    input wire [3:0] wstrb;
    input wire wvalid;
    output wire wready;
    output wire [1:0] bresp;
    output wire bvalid;
    input wire bready;
    input wire [3:0] araddr;
    input wire arvalid;
    output wire arready;
    output wire [31:0] rdata;
    output wire [1:0] rresp;
    output wire rvalid;
    input wire rready;

    localparam S_IDLE = 2'h0;
    localparam S_ACK = 2'h1;

    // ****************************************
    // helpers
    // ****************************************
    function mapped;
        input [3:0] a;
        begin
            mapped = (a == `DIRC_OFF_ST0) || (a == `DIRC_OFF_ST1) ||
                     (a == `DIRC_OFF_IMR) || (a == `DIRC_OFF_IFR);
        end
    endfunction

    // highest priority pending line, line 1 first
    function [2:0] pick;
        input [3:0] p;
        begin
            if (p[0]) begin
                pick = 3'h1;
            end else if (p[1]) begin
                pick = 3'h2;
            end else if (p[2]) begin
                pick = 3'h3;
            end else if (p[3]) begin
                pick = 3'h4;
            end else begin
                pick = 3'h0;
            end
        end
    endfunction

    reg [15:0] st0_q;
    reg xf_q;
    reg map_q;
    reg [3:0] imr_q;
    reg [3:0] ifr_q;
    reg nmi_pend_q;
    reg mclk_q;
    reg [1:0] state_q;
    reg [1:0] cnt_q;
    reg [15:0] vec_q;
    reg run_q;
    reg nmi_prev_q;
    reg [3:0] aw_q;
    reg aw_have_q;
    reg [31:0] w_q;
    reg [3:0] ws_q;
    reg w_have_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    wire [3:0] fall;
    wire in_reset;
    wire wr_go;
    wire [3:0] clr_ifr;
    wire nmi_fall;
    wire [3:0] enabled;
    wire [2:0] win;
    wire take;

    dirc_edge u_e1 (.aclk(aclk), .aresetn(aresetn), .line_n(ext_irq_line_1), .fall(fall[0]));
    dirc_edge u_e2 (.aclk(aclk), .aresetn(aresetn), .line_n(ext_irq_line_2), .fall(fall[1]));
    dirc_edge u_e3 (.aclk(aclk), .aresetn(aresetn), .line_n(ext_irq_line_3), .fall(fall[2]));
    dirc_edge u_e4 (.aclk(aclk), .aresetn(aresetn), .line_n(ext_irq_line_4), .fall(fall[3]));

    assign in_reset = ~system_reset_in_n;
    assign nmi_fall = nmi_prev_q & ~nmi_in_n;

    // ****************************************
    // bus write path
    // ****************************************
    assign awready = ~aw_have_q & ~bvalid_q;
    assign wready = ~w_have_q & ~bvalid_q;
    assign wr_go = aw_have_q & w_have_q & ~bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign clr_ifr = (wr_go && aw_q == `DIRC_OFF_IFR && ws_q[0]) ? w_q[3:0] : 4'h0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 4'h0;
            w_q <= 32'h0;
            ws_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `DIRC_RESP_OK;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_q <= wdata;
                ws_q <= wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= mapped(aw_q) ? `DIRC_RESP_OK : `DIRC_RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // status, mask, flag and map registers
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            st0_q <= `DIRC_ST0_RST;
            xf_q <= 1'b1;
            map_q <= 1'b0;
            imr_q <= `DIRC_IMR_RST;
        end else if (in_reset) begin
            xf_q <= 1'b1;
            map_q <= ~memory_map_select;
            st0_q <= `DIRC_ST0_RST;
        end else begin
            if (flag_instr) begin
                xf_q <= flag_instr_value;
            end
            if (wr_go && aw_q == `DIRC_OFF_ST0) begin
                if (ws_q[0]) st0_q[7:0] <= w_q[7:0];
                if (ws_q[1]) st0_q[15:8] <= w_q[15:8];
            end
            if (wr_go && aw_q == `DIRC_OFF_ST1 && ws_q[0]) begin
                xf_q <= w_q[`DIRC_ST1_XF];
                map_q <= ~w_q[`DIRC_ST1_MAP];
            end
            if (wr_go && aw_q == `DIRC_OFF_IMR && ws_q[0]) begin
                imr_q <= w_q[3:0];
            end
            // accepted maskable interrupt disables further ones
            if (take && win != 3'h0 && !nmi_pend_q) begin
                st0_q[`DIRC_ST0_GLOBAL_IRQ_DISABLE] <= 1'b1;
            end
        end
    end

    // ****************************************
    // interrupt flags, priority and acknowledge
    // ****************************************
    assign enabled = ifr_q & imr_q & {4{~st0_q[`DIRC_ST0_GLOBAL_IRQ_DISABLE]}};
    assign win = pick(enabled);
    assign take = run_q && state_q == S_IDLE && mclk_q && (nmi_pend_q || win != 3'h0);

    always @(posedge aclk) begin
        if (!aresetn) begin
            ifr_q <= 4'h0;
            nmi_pend_q <= 1'b0;
            nmi_prev_q <= 1'b1;
            state_q <= S_IDLE;
            cnt_q <= 2'h0;
            vec_q <= 16'h0000;
        end else if (in_reset) begin
            ifr_q <= 4'h0;
            nmi_pend_q <= 1'b0;
            nmi_prev_q <= nmi_in_n;
            state_q <= S_IDLE;
            cnt_q <= 2'h0;
            vec_q <= 16'h0000;
        end else begin
            nmi_prev_q <= nmi_in_n;
            // set wins over a clear in the same cycle
            ifr_q <= (ifr_q & ~clr_ifr) | fall;
            if (nmi_fall) begin
                nmi_pend_q <= 1'b1;
            end
            case (state_q)
                S_IDLE: begin
                    if (take) begin
                        state_q <= S_ACK;
                        cnt_q <= `DIRC_ACK_CYCLES;
                        if (nmi_pend_q) begin
                            vec_q <= `DIRC_VEC_NMI;
                            nmi_pend_q <= nmi_fall;
                        end else begin
                            vec_q <= `DIRC_VEC_EXT_IRQ_LINE_1 + {12'h000, win - 3'h1, 1'b0};
                            ifr_q <= ((ifr_q & ~clr_ifr) & ~(4'h1 << (win - 3'h1))) | fall;
                        end
                    end
                end
                S_ACK: begin
                    if (cnt_q == 2'h1) begin
                        state_q <= S_IDLE;
                        cnt_q <= 2'h0;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // reset sequencing and machine clock
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            mclk_q <= 1'b0;
        end else begin
            run_q <= system_reset_in_n;
            mclk_q <= ~mclk_q;
        end
    end

    assign fetch_enable = run_q & ~in_reset;
    assign irq_vector_valid = (state_q == S_ACK);
    assign address_lines = vec_q;
    assign internal_rom_mapped = map_q;
    assign branch_taken = branch_test & ~branch_condition_in & run_q;

    // ****************************************
    // pins with float control
    // ****************************************
    assign external_flag_out = xf_q;
    assign external_flag_out_en_n = ~output_float_n;
    assign irq_ack_out = ~(state_q == S_ACK);
    assign irq_ack_out_en_n = ~output_float_n;
    assign machine_clock_out = mclk_q;
    assign machine_clock_out_en_n = ~output_float_n;

    // ****************************************
    // bus read path
    // ****************************************
    assign arready = ~rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `DIRC_RESP_OK;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= mapped(araddr) ? `DIRC_RESP_OK : `DIRC_RESP_SLVERR;
            case (araddr)
                `DIRC_OFF_ST0: rdata_q <= {16'h0000, st0_q};
                `DIRC_OFF_ST1: rdata_q <= {27'h0, xf_q, 2'b00, run_q, ~map_q};
                `DIRC_OFF_IMR: rdata_q <= {28'h0, imr_q};
                `DIRC_OFF_IFR: rdata_q <= {26'h0, irq_ack_out, nmi_pend_q, ifr_q};
                default: rdata_q <= 32'h0;
            endcase
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule

// ===== dirc_ctrl_chk.sv
/* assertions on the control-pin block ports.
   assumes binding to dirc_ctrl, one clock domain. */
`include "dirc_regs.vh"
`timescale 1ns/10ps
module dirc_ctrl_chk (
    input wire aclk,
    input wire aresetn,
    input wire system_reset_in_n,
    input wire output_float_n,
    input wire branch_condition_in,
    input wire branch_test,
    input wire branch_taken,
    input wire nmi_in_n,
    input wire fetch_enable,
    input wire irq_vector_valid,
    input wire [15:0] address_lines,
    input wire internal_rom_mapped,
    input wire external_flag_out,
    input wire external_flag_out_en_n,
    input wire irq_ack_out,
    input wire irq_ack_out_en_n,
    input wire machine_clock_out,
    input wire machine_clock_out_en_n,
    input wire wvalid
);
    // ****
    // properties
    // ****
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_branch_low: assert property (branch_taken |-> branch_test && !branch_condition_in)
        else $error("branch taken with input high");
    a_float_ena: assert property ({external_flag_out_en_n, irq_ack_out_en_n,
        machine_clock_out_en_n} == {3{!output_float_n}})
        else $error("output enables do not follow float input");
    a_flag_reset: assert property (!system_reset_in_n |=> external_flag_out)
        else $error("flag not high in reset");
    a_ack_two: assert property ($fell(irq_ack_out) |-> irq_vector_valid ##1
        !irq_ack_out ##1 irq_ack_out)
        else $error("ack not two cycles with vector");
    a_pc_zero: assert property (!system_reset_in_n |-> !fetch_enable ##1
        address_lines == 16'h0000)
        else $error("fetch or address not zero in reset");
    a_fetch_start: assert property ($rose(system_reset_in_n) |-> ##[0:2] fetch_enable)
        else $error("fetch did not start");
    a_map_hold: assert property ($changed(internal_rom_mapped) |->
        !$past(system_reset_in_n) || $past(wvalid) || $past(wvalid, 2) || $past(wvalid, 3))
        else $error("map changed outside reset or write");
    a_mclk_toggle: assert property ($past(aresetn) |->
        machine_clock_out != $past(machine_clock_out))
        else $error("machine clock did not toggle");
    a_nmi_vec: assert property ($fell(nmi_in_n) && fetch_enable |-> ##[1:8]
        !irq_ack_out && address_lines == `DIRC_VEC_NMI)
        else $error("nmi not taken to its vector");
endmodule
bind dirc_ctrl dirc_ctrl_chk u_chk (.aclk, .aresetn, .system_reset_in_n, .output_float_n,
    .branch_condition_in, .branch_test, .branch_taken, .nmi_in_n, .fetch_enable,
    .irq_vector_valid, .address_lines, .internal_rom_mapped, .external_flag_out,
    .external_flag_out_en_n, .irq_ack_out, .irq_ack_out_en_n, .machine_clock_out,
    .machine_clock_out_en_n, .wvalid);

// ===== dirc_edge.v
/*
 * falling-edge detector for one active-low interrupt line.
 * assumes the line is synchronous to aclk.
 */
`timescale 1ns/10ps
module dirc_edge (
    aclk,
    aresetn,
    line_n,
    fall
);
    input wire aclk;
    input wire aresetn;
    input wire line_n;
    output wire fall;

    reg prev_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= line_n;
        end
    end

    assign fall = prev_q & ~line_n;
endmodule

// ===== dirc_regs.vh
/*
 * register map, field positions, reset values and codes for the control-pin block.
 * assumes a 32-bit AXI4-Lite slave with word-aligned byte addresses.
 */
`ifndef DIRC_REGS_VH
`define DIRC_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define DIRC_OFF_ST0 4'h0
`define DIRC_OFF_ST1 4'h4
`define DIRC_OFF_IMR 4'h8
`define DIRC_OFF_IFR 4'hC

// ****************************************
// fields
// ****************************************
`define DIRC_ST0_GLOBAL_IRQ_DISABLE 9
`define DIRC_ST1_XF 4
`define DIRC_ST1_MAP 0
`define DIRC_ST1_RUN 1
`define DIRC_IFR_NMI 4
`define DIRC_IFR_ACK 5

// ****************************************
// reset values
// ****************************************
`define DIRC_ST0_RST 16'h0200
`define DIRC_IMR_RST 4'h0

// ****************************************
// vectors and response codes
// ****************************************
`define DIRC_VEC_EXT_IRQ_LINE_1 16'h0002
`define DIRC_VEC_NMI 16'h0024
`define DIRC_RESP_OK 2'h0
`define DIRC_RESP_SLVERR 2'h2
`define DIRC_ACK_CYCLES 2'h2

`endif

// ===== dirc_src.sv
/* far-side model: interrupt sources and reset circuit.
   assumes tasks are called just after a rising aclk edge. */
`timescale 1ns/10ps
module dirc_src (
    input wire aclk,
    output logic [4:0] line_n,
    output logic rst_n,
    output logic map_sel
);
    // ****
    // pins
    // ****
    initial begin
        line_n = 5'h1F;
        rst_n = 1'h0;
        map_sel = 1'h1;
    end
    task fire(input int i);
        begin
            line_n[i] <= 1'h0;
            repeat (3) @(posedge aclk);
            line_n[i] <= 1'h1;
        end
    endtask
    // map steady across the pulse, flipped after it
    task rst(input logic m);
        begin
            map_sel <= m;
            rst_n <= 1'h0;
            repeat (4) @(posedge aclk);
            rst_n <= 1'h1;
            @(posedge aclk);
            map_sel <= ~m;
        end
    endtask
endmodule

// ===== dsp_interrupt_reset_control_pins_bench.sv
/* bench for dirc_ctrl: AXI4-Lite tasks and pin checks.
   assumes dirc_src drives the interrupt and reset pins. */
`include "dirc_regs.vh"
`timescale 1ns/10ps
module dsp_interrupt_reset_control_pins_bench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic output_float_n = 1'h1;
    logic branch_condition_in = 1'h1;
    logic branch_test = 1'h0;
    logic flag_instr = 1'h0;
    logic flag_instr_value = 1'h0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [3:0] wstrb = 4'h0;
    logic [3:0] ws = 4'hF;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [31:0] rd;
    logic [1:0] rs;
    integer miscompares = 0;
    integer n_checks = 0;
    wire [4:0] line_n;
    wire rst_n, map_sel, branch_taken, fetch_enable, irq_vector_valid, internal_rom_mapped;
    wire external_flag_out, external_flag_out_en_n, irq_ack_out, irq_ack_out_en_n;
    wire machine_clock_out, machine_clock_out_en_n, awready, wready, bvalid, arready, rvalid;
    wire [15:0] address_lines;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    dirc_src u_src (.aclk, .line_n, .rst_n, .map_sel);
    dirc_ctrl u_dut (.aclk, .aresetn, .system_reset_in_n(rst_n), .memory_map_select(map_sel),
        .output_float_n, .branch_condition_in, .branch_test, .branch_taken, .flag_instr,
        .flag_instr_value, .ext_irq_line_1(line_n[0]), .ext_irq_line_2(line_n[1]),
        .ext_irq_line_3(line_n[2]), .ext_irq_line_4(line_n[3]), .nmi_in_n(line_n[4]),
        .fetch_enable, .irq_vector_valid, .address_lines, .internal_rom_mapped,
        .external_flag_out, .external_flag_out_en_n, .irq_ack_out, .irq_ack_out_en_n,
        .machine_clock_out, .machine_clock_out_en_n, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);
    always #25 aclk = ~aclk;
    // ****
    // tasks
    // ****
    task end_sim;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            n_checks++;
            if (g !== e) begin
                miscompares++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task c1(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        begin
            awaddr <= a;
            wdata <= d;
            wstrb <= ws;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            aw = 1'h0;
            w = 1'h0;
            while (!(aw && w)) begin
                @(posedge aclk);
                if (awvalid && awready) begin
                    aw = 1'h1;
                    awvalid <= 1'h0;
                end
                if (wvalid && wready) begin
                    w = 1'h1;
                    wvalid <= 1'h0;
                end
            end
            bready <= 1'h1;
            do @(posedge aclk); while (bvalid !== 1'h1);
            bready <= 1'h0;
            rs = bresp;
        end
    endtask
    task rg(input logic [3:0] a);
        begin
            araddr <= a;
            arvalid <= 1'h1;
            do @(posedge aclk); while (arready !== 1'h1);
            arvalid <= 1'h0;
            rready <= 1'h1;
            do @(posedge aclk); while (rvalid !== 1'h1);
            rready <= 1'h0;
            rd = rdata;
            rs = rresp;
        end
    endtask
    task rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        begin
            rg(a);
            chk(rd & m, e);
        end
    endtask
    task ack(input logic [15:0] e);
        begin
            do @(posedge aclk); while (irq_ack_out !== 1'h0);
            chk({16'h0, address_lines}, {16'h0, e});
            c1(irq_vector_valid, 1'h1);
            repeat (3) @(posedge aclk);
        end
    endtask
    task flg(input logic v);
        begin
            flag_instr_value <= v;
            flag_instr <= 1'h1;
            @(posedge aclk);
            flag_instr <= 1'h0;
            repeat (2) @(posedge aclk);
            c1(external_flag_out, v);
        end
    endtask
    // ****
    // tests
    // ****
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        u_src.rst(1'h1);
        repeat (2) @(posedge aclk);
        rc(`DIRC_OFF_ST0, 32'hFFFF, {16'h0, `DIRC_ST0_RST});
        rc(`DIRC_OFF_IMR, 32'hF, 32'h0);
        rc(`DIRC_OFF_ST1, 32'h13, 32'h13);
        c1(internal_rom_mapped, 1'h0);
        rg(4'h2);
        chk({30'h0, rs}, {30'h0, `DIRC_RESP_SLVERR});
        chk(rd, 32'h0);
        wr(`DIRC_OFF_ST1, 32'h0);
        chk({30'h0, rs}, {30'h0, `DIRC_RESP_OK});
        c1(external_flag_out, 1'h0);
        c1(internal_rom_mapped, 1'h1);
        flg(1'h1);
        output_float_n <= 1'h0;
        repeat (2) @(posedge aclk);
        chk({29'h0, external_flag_out_en_n, irq_ack_out_en_n, machine_clock_out_en_n}, 32'h7);
        rd[0] = machine_clock_out;
        @(posedge aclk);
        c1(machine_clock_out, ~rd[0]);
        output_float_n <= 1'h1;
        branch_test <= 1'h1;
        branch_condition_in <= 1'h0;
        repeat (2) @(posedge aclk);
        c1(branch_taken, 1'h1);
        branch_condition_in <= 1'h1;
        repeat (2) @(posedge aclk);
        c1(branch_taken, 1'h0);
        branch_test <= 1'h0;
        u_src.fire(1);
        u_src.fire(2);
        rc(`DIRC_OFF_IFR, 32'hF, 32'h6);
        wr(`DIRC_OFF_IFR, 32'h2);
        rc(`DIRC_OFF_IFR, 32'hF, 32'h4);
        wr(`DIRC_OFF_IMR, 32'hF);
        u_src.fire(0);
        rc(`DIRC_OFF_IFR, 32'hF, 32'h5);
        fork wr(`DIRC_OFF_ST0, 32'h0); ack(`DIRC_VEC_EXT_IRQ_LINE_1); join
        fork wr(`DIRC_OFF_ST0, 32'h0); ack(`DIRC_VEC_EXT_IRQ_LINE_1 + 16'h4); join
        rc(`DIRC_OFF_ST0, 32'h200, 32'h200);
        ws = 4'h1;
        wr(`DIRC_OFF_ST0, 32'h0);
        ws = 4'hF;
        rc(`DIRC_OFF_ST0, 32'h200, 32'h200);
        wr(`DIRC_OFF_IMR, 32'h0);
        fork u_src.fire(4); ack(`DIRC_VEC_NMI); join
        flg(1'h0);
        u_src.fire(3);
        rc(`DIRC_OFF_IFR, 32'hF, 32'h8);
        wr(`DIRC_OFF_ST1, 32'h1);
        c1(internal_rom_mapped, 1'h0);
        fork u_src.rst(1'h0); begin repeat (2) @(posedge aclk); c1(fetch_enable, 1'h0); end join
        repeat (3) @(posedge aclk);
        c1(internal_rom_mapped, 1'h1);
        c1(external_flag_out, 1'h1);
        rc(`DIRC_OFF_IFR, 32'hF, 32'h0);
        c1(fetch_enable, 1'h1);
        end_sim;
    end
endmodule
